// ===== shared/dser_pkg.sv
package dser_pkg;

    localparam int NUM_CTRL = 4;
    localparam int NUM_CHAN = 4;
    localparam int NUM_TOT  = NUM_CTRL * NUM_CHAN;
    localparam int NUM_SRC  = 20;
    localparam int CODE_W   = 4;
    localparam int NUM_CODE = 16;
    localparam int ADDR_W   = 16;
    localparam int DATA_W   = 32;
    localparam int REG_W    = 16;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_FLAG   = 16'h1C30;
    localparam logic [15:0] IDX_ENABLE = 16'h1C31;
    localparam logic [15:0] IDX_LOW_SRC  [NUM_CTRL] =
        '{16'h1C1A, 16'h1C1C, 16'h1C36, 16'h1C38};
    localparam logic [15:0] IDX_HIGH_SRC [NUM_CTRL] =
        '{16'h1C1B, 16'h1C1D, 16'h1C37, 16'h1C39};

    // Event source register fields
    localparam int EVEN_LSB = 0;
    localparam int ODD_LSB  = 8;

    localparam logic [CODE_W-1:0] CODE_RST = 4'h0;
    localparam logic [REG_W-1:0]  FLAG_RST = 16'h0000;
    localparam logic [REG_W-1:0]  ENA_RST  = 16'h0000;

    // Select codes
    localparam logic [CODE_W-1:0] CODE_PORT_TX  = 4'h1;
    localparam logic [CODE_W-1:0] CODE_PORT_RX  = 4'h2;
    localparam logic [CODE_W-1:0] CODE_ADC      = 4'h3;
    localparam logic [CODE_W-1:0] CODE_SAP3_TX  = 4'h4;
    localparam logic [CODE_W-1:0] CODE_SAP3_RX  = 4'h5;
    localparam logic [CODE_W-1:0] CODE_CARD0_TX = 4'h5;
    localparam logic [CODE_W-1:0] CODE_CARD0_RX = 4'h6;
    localparam logic [CODE_W-1:0] CODE_CARD1_TX = 4'h7;
    localparam logic [CODE_W-1:0] CODE_CARD1_RX = 4'h8;
    localparam logic [CODE_W-1:0] CODE_UART_TX  = 4'h5;
    localparam logic [CODE_W-1:0] CODE_UART_RX  = 4'h6;
    localparam logic [CODE_W-1:0] CODE_TIMER0   = 4'hC;
    localparam logic [CODE_W-1:0] CODE_TIMER1   = 4'hD;
    localparam logic [CODE_W-1:0] CODE_TIMER2   = 4'hE;

    // Bit positions of the event source input vector
    localparam int SRC_SAP0_TX  = 0;
    localparam int SRC_SAP0_RX  = 1;
    localparam int SRC_SAP1_TX  = 2;
    localparam int SRC_SAP1_RX  = 3;
    localparam int SRC_SAP2_TX  = 4;
    localparam int SRC_SAP2_RX  = 5;
    localparam int SRC_SAP3_TX  = 6;
    localparam int SRC_SAP3_RX  = 7;
    localparam int SRC_I2C_TX   = 8;
    localparam int SRC_I2C_RX   = 9;
    localparam int SRC_UART_TX  = 10;
    localparam int SRC_UART_RX  = 11;
    localparam int SRC_CARD0_TX = 12;
    localparam int SRC_CARD0_RX = 13;
    localparam int SRC_CARD1_TX = 14;
    localparam int SRC_CARD1_RX = 15;
    localparam int SRC_ADC      = 16;
    localparam int SRC_TIMER0   = 17;
    localparam int SRC_TIMER1   = 18;
    localparam int SRC_TIMER2   = 19;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== rtl/dser_chan_select.sv
`timescale 1ns/1ns
module dser_chan_select import dser_pkg::*; (
    input  wire logic                clk_i,
    input  wire logic                reset_i,
    input  wire logic [NUM_CODE-1:0] event_lines_i,
    input  wire logic [CODE_W-1:0]   code_i,
    input  wire logic                wait_en_i,
    output logic                     req_o
);

    typedef struct packed {
        logic req;
    } dser_sel_s;

    dser_sel_s state_reg;
    dser_sel_s state_next;

    // Reserved codes index lines that are tied low
    always_comb begin
        state_next     = state_reg;
        state_next.req = wait_en_i & event_lines_i[code_i];
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign req_o = state_reg.req;

endmodule // dser_chan_select

// ===== rtl/dser_axil_slave.sv
`timescale 1ns/1ns
module dser_axil_slave import dser_pkg::*; (
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    input  wire logic [DATA_W-1:0] s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    output logic [1:0]             s_axi_bresp_o,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    output logic [DATA_W-1:0]      s_axi_rdata_o,
    output logic [1:0]             s_axi_rresp_o,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    output logic                   wr_req_o,
    output logic [ADDR_W-1:0]      wr_addr_o,
    output logic [DATA_W-1:0]      wr_data_o,
    output logic [3:0]             wr_strb_o,
    input  wire logic              wr_hit_i,
    output logic [ADDR_W-1:0]      rd_addr_o,
    input  wire logic [DATA_W-1:0] rd_data_i,
    input  wire logic              rd_hit_i
);

    typedef struct packed {
        logic              aw_full;
        logic [ADDR_W-1:0] awaddr;
        logic              w_full;
        logic [DATA_W-1:0] wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
    } dser_axi_s;

    dser_axi_s state_reg;
    dser_axi_s state_next;

    // No new write is taken until the response has left
    assign s_axi_awready_o = ~state_reg.aw_full & ~state_reg.bvalid;
    assign s_axi_wready_o  = ~state_reg.w_full & ~state_reg.bvalid;
    assign s_axi_arready_o = ~state_reg.rvalid;
    assign wr_req_o = state_reg.aw_full & state_reg.w_full
                      & ~state_reg.bvalid;
    assign rd_addr_o = s_axi_araddr_i;

    always_comb begin
        state_next = state_reg;
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            state_next.aw_full = 1'b1;
            state_next.awaddr  = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            state_next.w_full = 1'b1;
            state_next.wdata  = s_axi_wdata_i;
            state_next.wstrb  = s_axi_wstrb_i;
        end
        if (wr_req_o) begin
            state_next.aw_full = 1'b0;
            state_next.w_full  = 1'b0;
            state_next.bvalid  = 1'b1;
            state_next.bresp   = wr_hit_i ? RESP_OKAY : RESP_SLVERR;
        end else if (state_reg.bvalid && s_axi_bready_i) begin
            state_next.bvalid = 1'b0;
        end
        if (s_axi_arvalid_i && s_axi_arready_o) begin
            state_next.rvalid = 1'b1;
            state_next.rdata  = rd_data_i;
            state_next.rresp  = rd_hit_i ? RESP_OKAY : RESP_SLVERR;
        end else if (state_reg.rvalid && s_axi_rready_i) begin
            state_next.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign wr_addr_o      = state_reg.awaddr;
    assign wr_data_o      = state_reg.wdata;
    assign wr_strb_o      = state_reg.wstrb;
    assign s_axi_bvalid_o = state_reg.bvalid;
    assign s_axi_bresp_o  = state_reg.bresp;
    assign s_axi_rvalid_o = state_reg.rvalid;
    assign s_axi_rdata_o  = state_reg.rdata;
    assign s_axi_rresp_o  = state_reg.rresp;

endmodule // dser_axil_slave

// ===== rtl/dser_event_router.sv
`timescale 1ns/1ns
// How it works
// - There are four controllers of four channels, each channel with
//   its own event selection.
// - The controllers move data in the background; this block only
//   starts them and reports their completion.
// - Each channel gets its own event request that starts its transfer.
// - Each channel has its own completion interrupt toward the CPU.
// - A channel can be synchronised to any event of its controller.
// - Twenty distinct event sources exist across the system.
// - Every channel picks its event independently of the others.
// - Codes C, D and E pick timers 0 to 2; 0, 9 to B and F are reserved.
// - Controller 0 maps audio port 0 and card hosts 0 and 1; controller
//   1 maps audio port 2 and the UART.
// - Controller 2 maps I2C, the converter and audio port 3;
//   controller 3 maps audio port 1; other non-timer codes are reserved.
// - The selected event reaches a channel only while its sync wait
//   enable is 1.
// - The low source register serves channels 0 and 1, the high one
//   channels 2 and 3.
// - Even channel code in bits 3:0, odd in 11:8, other bits read
//   zero, codes reset to zero.
// - Any number of channels and controllers may share one event.
module dser_event_router import dser_pkg::*; (
    input  wire logic               clk_i,
    input  wire logic               reset_i,
    input  wire logic [ADDR_W-1:0]  s_axi_awaddr_i,
    input  wire logic               s_axi_awvalid_i,
    output logic                    s_axi_awready_o,
    input  wire logic [DATA_W-1:0]  s_axi_wdata_i,
    input  wire logic [3:0]         s_axi_wstrb_i,
    input  wire logic               s_axi_wvalid_i,
    output logic                    s_axi_wready_o,
    output logic [1:0]              s_axi_bresp_o,
    output logic                    s_axi_bvalid_o,
    input  wire logic               s_axi_bready_i,
    input  wire logic [ADDR_W-1:0]  s_axi_araddr_i,
    input  wire logic               s_axi_arvalid_i,
    output logic                    s_axi_arready_o,
    output logic [DATA_W-1:0]       s_axi_rdata_o,
    output logic [1:0]              s_axi_rresp_o,
    output logic                    s_axi_rvalid_o,
    input  wire logic               s_axi_rready_i,
    input  wire logic [NUM_SRC-1:0] event_src_i,
    input  wire logic [NUM_TOT-1:0] sync_wait_enable_i,
    input  wire logic [NUM_TOT-1:0] chan_done_i,
    output logic [NUM_TOT-1:0]      chan_sync_req_o,
    output logic [NUM_TOT-1:0]      chan_irq_o,
    output logic                    dma_irq_o
);

    typedef struct packed {
        logic [NUM_SRC-1:0]        src_prev;
        logic [NUM_TOT*CODE_W-1:0] codes;
        logic [REG_W-1:0]          flag;
        logic [REG_W-1:0]          enable;
        logic [NUM_TOT-1:0]        irq_ch;
        logic                      irq;
    } dser_main_s;

    dser_main_s state_reg;
    dser_main_s state_next;

    logic                     wr_req;
    logic [ADDR_W-1:0]        wr_addr;
    logic [DATA_W-1:0]        wr_data;
    logic [3:0]               wr_strb;
    logic                     wr_hit;
    logic [ADDR_W-1:0]        rd_addr;
    logic [DATA_W-1:0]        rd_data;
    logic                     rd_hit;
    logic [NUM_SRC-1:0]       src_pulse;
    logic [4:0]               wr_sel;
    logic [4:0]               rd_sel;

    // Register decode: bit 4 is the hit, bits 3:0 pick the register.
    // 0 flag, 1 enable, 2+2n low source of n, 3+2n high source of n.
    function automatic logic [4:0] reg_decode(
        input logic [ADDR_W-1:0] addr
    );
        logic [ADDR_W-3:0] word;
        logic [4:0]        res;
        word = addr[ADDR_W-1:2];
        res  = 5'h00;
        if (word == IDX_FLAG[ADDR_W-3:0]) begin
            res = 5'h10;
        end
        if (word == IDX_ENABLE[ADDR_W-3:0]) begin
            res = 5'h11;
        end
        for (int n = 0; n < NUM_CTRL; n++) begin
            if (word == IDX_LOW_SRC[n][ADDR_W-3:0]) begin
                res = {1'b1, 4'(2 + 2 * n)};
            end
            if (word == IDX_HIGH_SRC[n][ADDR_W-3:0]) begin
                res = {1'b1, 4'(3 + 2 * n)};
            end
        end
        return res;
    endfunction

    // Per controller table of code to event line; unlisted codes stay low
    function automatic logic [NUM_CODE-1:0] code_lines(
        input int                 ctrl,
        input logic [NUM_SRC-1:0] p
    );
        logic [NUM_CODE-1:0] l;
        l = '0;
        l[CODE_TIMER0] = p[SRC_TIMER0];
        l[CODE_TIMER1] = p[SRC_TIMER1];
        l[CODE_TIMER2] = p[SRC_TIMER2];
        unique case (ctrl)
            0: begin
                l[CODE_PORT_TX]  = p[SRC_SAP0_TX];
                l[CODE_PORT_RX]  = p[SRC_SAP0_RX];
                l[CODE_CARD0_TX] = p[SRC_CARD0_TX];
                l[CODE_CARD0_RX] = p[SRC_CARD0_RX];
                l[CODE_CARD1_TX] = p[SRC_CARD1_TX];
                l[CODE_CARD1_RX] = p[SRC_CARD1_RX];
            end
            1: begin
                l[CODE_PORT_TX] = p[SRC_SAP2_TX];
                l[CODE_PORT_RX] = p[SRC_SAP2_RX];
                l[CODE_UART_TX] = p[SRC_UART_TX];
                l[CODE_UART_RX] = p[SRC_UART_RX];
            end
            2: begin
                l[CODE_PORT_TX] = p[SRC_I2C_TX];
                l[CODE_PORT_RX] = p[SRC_I2C_RX];
                l[CODE_ADC]     = p[SRC_ADC];
                l[CODE_SAP3_TX] = p[SRC_SAP3_TX];
                l[CODE_SAP3_RX] = p[SRC_SAP3_RX];
            end
            default: begin
                l[CODE_PORT_TX] = p[SRC_SAP1_TX];
                l[CODE_PORT_RX] = p[SRC_SAP1_RX];
            end
        endcase
        return l;
    endfunction

    // Source register image of controller n, half h (0 low, 1 high)
    function automatic logic [REG_W-1:0] src_image(
        input logic [NUM_TOT*CODE_W-1:0] codes,
        input int                        n,
        input int                        h
    );
        logic [REG_W-1:0] v;
        int               ch;
        ch = n * NUM_CHAN + 2 * h;
        v  = '0;
        v[EVEN_LSB +: CODE_W] = codes[ch * CODE_W +: CODE_W];
        v[ODD_LSB +: CODE_W]  = codes[(ch + 1) * CODE_W +: CODE_W];
        return v;
    endfunction

    dser_axil_slave u_bus (
        .clk_i           (clk_i),
        .reset_i         (reset_i),
        .s_axi_awaddr_i  (s_axi_awaddr_i),
        .s_axi_awvalid_i (s_axi_awvalid_i),
        .s_axi_awready_o (s_axi_awready_o),
        .s_axi_wdata_i   (s_axi_wdata_i),
        .s_axi_wstrb_i   (s_axi_wstrb_i),
        .s_axi_wvalid_i  (s_axi_wvalid_i),
        .s_axi_wready_o  (s_axi_wready_o),
        .s_axi_bresp_o   (s_axi_bresp_o),
        .s_axi_bvalid_o  (s_axi_bvalid_o),
        .s_axi_bready_i  (s_axi_bready_i),
        .s_axi_araddr_i  (s_axi_araddr_i),
        .s_axi_arvalid_i (s_axi_arvalid_i),
        .s_axi_arready_o (s_axi_arready_o),
        .s_axi_rdata_o   (s_axi_rdata_o),
        .s_axi_rresp_o   (s_axi_rresp_o),
        .s_axi_rvalid_o  (s_axi_rvalid_o),
        .s_axi_rready_i  (s_axi_rready_i),
        .wr_req_o        (wr_req),
        .wr_addr_o       (wr_addr),
        .wr_data_o       (wr_data),
        .wr_strb_o       (wr_strb),
        .wr_hit_i        (wr_hit),
        .rd_addr_o       (rd_addr),
        .rd_data_i       (rd_data),
        .rd_hit_i        (rd_hit)
    );

    assign wr_sel = reg_decode(wr_addr);
    assign rd_sel = reg_decode(rd_addr);
    assign wr_hit = wr_sel[4];
    assign rd_hit = rd_sel[4];

    // Level sources collapse to one pulse per rising edge
    assign src_pulse = event_src_i & ~state_reg.src_prev;

    always_comb begin
        rd_data = '0;
        if (rd_sel == 5'h10) begin
            rd_data[REG_W-1:0] = state_reg.flag;
        end else if (rd_sel == 5'h11) begin
            rd_data[REG_W-1:0] = state_reg.enable;
        end else if (rd_hit) begin
            rd_data[REG_W-1:0] = src_image(state_reg.codes,
                                           int'(rd_sel[3:1]) - 1,
                                           int'(rd_sel[0]));
        end
    end

    always_comb begin
        int               ch;
        logic [REG_W-1:0] clr;
        ch         = 0;
        clr        = '0;
        state_next = state_reg;
        state_next.src_prev = event_src_i;
        if (wr_req && wr_sel == 5'h10) begin
            clr = {{8{wr_strb[1]}}, {8{wr_strb[0]}}} & wr_data[REG_W-1:0];
        end
        if (wr_req && wr_sel == 5'h11) begin
            if (wr_strb[0]) begin
                state_next.enable[7:0] = wr_data[7:0];
            end
            if (wr_strb[1]) begin
                state_next.enable[15:8] = wr_data[15:8];
            end
        end
        if (wr_req && wr_hit && wr_sel[3:1] != 3'h0) begin
            // Each channel owns its field; others are never touched
            ch = (int'(wr_sel[3:1]) - 1) * NUM_CHAN + 2 * int'(wr_sel[0]);
            if (wr_strb[0]) begin
                state_next.codes[ch * CODE_W +: CODE_W] =
                    wr_data[EVEN_LSB +: CODE_W];
            end
            if (wr_strb[1]) begin
                state_next.codes[(ch + 1) * CODE_W +: CODE_W] =
                    wr_data[ODD_LSB +: CODE_W];
            end
        end
        // A completion in the clearing cycle keeps its flag set
        state_next.flag   = (state_reg.flag & ~clr) | chan_done_i;
        state_next.irq_ch = state_reg.flag & state_reg.enable;
        state_next.irq    = |(state_reg.flag & state_reg.enable);
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg        <= '0;
            state_reg.codes  <= {NUM_TOT{CODE_RST}};
            state_reg.flag   <= FLAG_RST;
            state_reg.enable <= ENA_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // One selector per channel, each fed the full line set of its
    // controller, so any number of channels can share an event.
    // The transfers themselves run in the controllers in the background.
    for (genvar n = 0; n < NUM_CTRL; n++) begin : g_ctrl
        logic [NUM_CODE-1:0] lines;
        assign lines = code_lines(n, src_pulse);
        for (genvar m = 0; m < NUM_CHAN; m++) begin : g_chan
            localparam int CH = n * NUM_CHAN + m;
            dser_chan_select u_sel (
                .clk_i         (clk_i),
                .reset_i       (reset_i),
                .event_lines_i (lines),
                .code_i        (state_reg.codes[CH * CODE_W +: CODE_W]),
                .wait_en_i     (sync_wait_enable_i[CH]),
                .req_o         (chan_sync_req_o[CH])
            );
        end
    end

    assign chan_irq_o = state_reg.irq_ch;
    assign dma_irq_o  = state_reg.irq;

endmodule // dser_event_router

// ===== verification/dser_event_router_chk.sv
`timescale 1ns/1ns
module dser_event_router_chk import dser_pkg::*; (
    input  wire logic               clk_i,
    input  wire logic               reset_i,
    input  wire logic               s_axi_awvalid_i,
    input  wire logic               s_axi_awready_o,
    input  wire logic               s_axi_wvalid_i,
    input  wire logic               s_axi_wready_o,
    input  wire logic               s_axi_bvalid_o,
    input  wire logic               s_axi_arvalid_i,
    input  wire logic               s_axi_arready_o,
    input  wire logic               s_axi_rvalid_o,
    input  wire logic [NUM_SRC-1:0] event_src_i,
    input  wire logic [NUM_TOT-1:0] sync_wait_enable_i,
    input  wire logic [NUM_TOT-1:0] chan_sync_req_o,
    input  wire logic [NUM_TOT-1:0] chan_irq_o,
    input  wire logic               dma_irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    chk_req_single: assert property (
        !(|(chan_sync_req_o & $past(chan_sync_req_o))))
        else $error("sync request longer than one cycle");
    chk_req_gated: assert property (
        !(|(chan_sync_req_o & ~$past(sync_wait_enable_i))))
        else $error("sync request while wait disabled");
    chk_req_cause: assert property (
        |chan_sync_req_o |->
            |($past(event_src_i) & ~$past(event_src_i, 2)))
        else $error("sync request without a source edge");
    chk_irq_or: assert property (dma_irq_o == |chan_irq_o)
        else $error("summary interrupt differs from channels");
    chk_reset_clear: assert property ($fell(reset_i) |->
        !dma_irq_o && chan_sync_req_o == '0 && !s_axi_bvalid_o)
        else $error("outputs not idle after reset");
    chk_write_resp: assert property (s_axi_awvalid_i && s_axi_awready_o
        && s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
        else $error("write response late");
    chk_read_resp: assert property (
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read response late");
    chk_busy_refuse: assert property (
        s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write accepted while response pending");
endmodule // dser_event_router_chk

bind dser_event_router dser_event_router_chk u_chk (
    .clk_i(clk_i), .reset_i(reset_i),
    .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
    .event_src_i(event_src_i), .sync_wait_enable_i(sync_wait_enable_i),
    .chan_sync_req_o(chan_sync_req_o), .chan_irq_o(chan_irq_o),
    .dma_irq_o(dma_irq_o)
);

// ===== verification/dser_far_side_model.sv
`timescale 1ns/1ns
module dser_far_side_model import dser_pkg::*; (
    input  wire logic               clk_i,
    input  wire logic [NUM_SRC-1:0] fire_i,
    input  wire logic [NUM_TOT-1:0] req_i,
    output logic      [NUM_SRC-1:0] event_src_o,
    output logic      [NUM_TOT-1:0] done_o
);
    logic [NUM_TOT-1:0] busy_reg;

    // Sources pulse one cycle so each request can rise again at once
    always_ff @(posedge clk_i) begin
        event_src_o <= fire_i;
        busy_reg    <= req_i;
        done_o      <= busy_reg;
    end
endmodule // dser_far_side_model

// ===== verification/test_dser_event_router.sv
`timescale 1ns/1ns
module test_dser_event_router import dser_pkg::*;;
    localparam int MAP [20] = '{'h0100, 'h0201, 'h050C, 'h060D, 'h070E,
        'h080F, 'h0C11, 'h0D12, 'h0E13, 'h1104, 'h1205, 'h150A, 'h160B,
        'h2108, 'h2209, 'h2310, 'h2406, 'h2507, 'h3102, 'h3203};
    logic               clk_i   = 1'b0;
    logic               reset_i = 1'b1;
    logic [ADDR_W-1:0]  awaddr  = '0;
    logic [ADDR_W-1:0]  araddr  = '0;
    logic [DATA_W-1:0]  wdata   = '0;
    logic               awvalid = 1'b0;
    logic               wvalid  = 1'b0;
    logic               bready  = 1'b0;
    logic               arvalid = 1'b0;
    logic               rready  = 1'b0;
    logic [NUM_TOT-1:0] wait_en = '1;
    logic [NUM_SRC-1:0] fire    = '0;
    logic [NUM_TOT-1:0] seen;
    wire logic          awready, wready, bvalid, arready, rvalid, dma_irq;
    wire logic [1:0]    bresp, rresp;
    wire logic [DATA_W-1:0] rdata;
    wire logic [NUM_SRC-1:0] src;
    wire logic [NUM_TOT-1:0] done, req, irq;
    int                 bad_count  = 0;
    int                 n_compared = 0;
    int                 c, i, k;
    bit                 hit;

    initial forever #2 clk_i = ~clk_i;

    dser_event_router i_dut (.clk_i(clk_i), .reset_i(reset_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .event_src_i(src),
        .sync_wait_enable_i(wait_en), .chan_done_i(done),
        .chan_sync_req_o(req), .chan_irq_o(irq), .dma_irq_o(dma_irq));

    dser_far_side_model i_far (.clk_i(clk_i), .fire_i(fire), .req_i(req),
        .event_src_o(src), .done_o(done));

    task automatic tally_and_finish(input bit hang);
        if (hang) bad_count++;
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // Sampling at the falling edge sees what the next rising edge takes
    task automatic axw(input logic [15:0] a, input logic [31:0] d,
                       input logic [1:0] er);
        logic ta, tw, tb;
        @(posedge clk_i);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        tb = 1'b0;
        for (int n = 0; n < 40 && !tb; n++) begin
            @(negedge clk_i);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid && bready;
            if (tb) chk(bresp, er);
            @(posedge clk_i);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
        end
        if (!tb) tally_and_finish(1'b1);
    endtask

    task automatic axr(input logic [15:0] a, input logic [31:0] d,
                       input logic [1:0] er);
        logic ta, tr;
        @(posedge clk_i);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        tr = 1'b0;
        for (int n = 0; n < 40 && !tr; n++) begin
            @(negedge clk_i);
            ta = arvalid && arready;
            tr = rvalid && rready;
            if (tr) chk(rdata, d);
            if (tr) chk(rresp, er);
            @(posedge clk_i);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
        end
        if (!tr) tally_and_finish(1'b1);
    endtask

    // Program one channel, fire sources, collect requests, then unprogram
    task automatic go(input int cc, input int ch, input int code,
                      input logic [NUM_SRC-1:0] v,
                      input logic [NUM_TOT-1:0] e);
        logic [15:0] a;
        a = (ch < 2 ? IDX_LOW_SRC[cc] : IDX_HIGH_SRC[cc]) << 2;
        axw(a, 32'(code) << (ch % 2 * ODD_LSB), RESP_OKAY);
        fire <= v;
        seen = '0;
        repeat (6) begin
            @(negedge clk_i);
            seen |= req;
            @(posedge clk_i);
            fire <= '0;
        end
        chk(seen, e);
        axw(a, 32'h0, RESP_OKAY);
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        for (c = 0; c < NUM_CTRL; c++) begin
            axr(IDX_LOW_SRC[c] << 2, 32'h0, RESP_OKAY);
            axr(IDX_HIGH_SRC[c] << 2, 32'h0, RESP_OKAY);
        end
        axr(IDX_FLAG << 2, 32'h0, RESP_OKAY);
        axr(IDX_ENABLE << 2, 32'h0, RESP_OKAY);
        axw(IDX_HIGH_SRC[2] << 2, 32'hFFFFFFFF, RESP_OKAY);
        axr(IDX_HIGH_SRC[2] << 2, 32'h00000F0F, RESP_OKAY);
        axr(IDX_LOW_SRC[2] << 2, 32'h0, RESP_OKAY);
        axw(IDX_HIGH_SRC[2] << 2, 32'h0, RESP_OKAY);
        for (i = 0; i < 20; i++) begin
            c = MAP[i] >> 12;
            go(c, i % 4, (MAP[i] >> 8) & 15, 20'h1 << (MAP[i] & 255),
               16'h1 << (c * 4 + i % 4));
        end
        for (c = 0; c < NUM_CTRL; c++)
            for (k = 0; k < NUM_CODE; k++) begin
                hit = k >= 12 && k <= 14;
                for (i = 0; i < 20; i++)
                    if ((MAP[i] >> 8) == c * 16 + k) hit = 1'b1;
                go(c, k % 4, k, '1,
                   hit ? 16'h1 << (c * 4 + k % 4) : 16'h0);
            end
        axw(IDX_HIGH_SRC[3] << 2, 32'h00000D00, RESP_OKAY);
        go(0, 0, CODE_TIMER1, 20'h1 << SRC_TIMER1, 16'h8001);
        axw(IDX_HIGH_SRC[3] << 2, 32'h0, RESP_OKAY);
        wait_en <= 16'hFFFE;
        go(0, 0, CODE_TIMER0, 20'h1 << SRC_TIMER0, 16'h0);
        wait_en <= '1;
        axw(IDX_FLAG << 2, 32'h0000FFFF, RESP_OKAY);
        axr(IDX_FLAG << 2, 32'h0, RESP_OKAY);
        axw(IDX_ENABLE << 2, 32'h00000020, RESP_OKAY);
        go(1, 1, CODE_UART_RX, 20'h1 << SRC_UART_RX, 16'h0020);
        axr(IDX_FLAG << 2, 32'h00000020, RESP_OKAY);
        @(negedge clk_i);
        chk(irq, 16'h0020);
        chk(dma_irq, 1'b1);
        axw(IDX_ENABLE << 2, 32'h0, RESP_OKAY);
        repeat (2) @(negedge clk_i);
        chk(dma_irq, 1'b0);
        axw(IDX_ENABLE << 2, 32'h00000020, RESP_OKAY);
        axw(IDX_FLAG << 2, 32'h00000020, RESP_OKAY);
        axr(IDX_FLAG << 2, 32'h0, RESP_OKAY);
        repeat (2) @(negedge clk_i);
        chk(dma_irq, 1'b0);
        axw(16'h7000, 32'h1, RESP_SLVERR);
        axr(16'h7000, 32'h0, RESP_SLVERR);
        tally_and_finish(1'b0);
    end
endmodule // test_dser_event_router
